// ---- rtl/apfg_pkg.sv ----
// Shared constants and types of the audio port flag and GPIO block.
package apfg_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 24;
    localparam int unsigned PIN_N  = 12;
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned TX_N   = 6;
    localparam int unsigned RX_N   = 4;

    // Register indices on the register port.
    localparam logic [ADDR_W-1:0] REG_FUNC  = 3'h0;
    localparam logic [ADDR_W-1:0] REG_DIR   = 3'h1;
    localparam logic [ADDR_W-1:0] REG_DATA  = 3'h2;
    localparam logic [ADDR_W-1:0] REG_CCTRL = 3'h3;
    localparam logic [ADDR_W-1:0] REG_RCTRL = 3'h4;
    localparam logic [ADDR_W-1:0] REG_TCTRL = 3'h5;
    localparam logic [ADDR_W-1:0] REG_STAT  = 3'h6;

    // Common control register fields.
    localparam int unsigned CC_SYNC_BIT = 0;
    localparam int unsigned CC_OFLAG_LO = 1;
    localparam int unsigned CC_TX_BUFFER_ENABLE_SELECT_BIT = 4;

    // Receive control register fields.
    localparam int unsigned RC_EN_LO    = 0;
    localparam int unsigned RC_HOLD_BIT = 4;
    localparam int unsigned RC_CKD_BIT  = 5;
    localparam int unsigned RC_FSD_BIT  = 6;
    localparam int unsigned RC_HCKD_BIT = 7;

    // Transmit control register fields.
    localparam int unsigned TC_EN_LO    = 0;
    localparam int unsigned TC_HOLD_BIT = 6;

    // Common status register fields.
    localparam int unsigned ST_IFLAG_LO = 0;
    localparam int unsigned ST_TDE_BIT  = 3;
    localparam int unsigned ST_RXRUN_BIT = 4;
    localparam int unsigned ST_IRST_BIT = 5;

    // Port pins that double as serial flags 0, 1 and 2.
    localparam int unsigned PIN_FLAG0 = 0;
    localparam int unsigned PIN_FLAG1 = 1;
    localparam int unsigned PIN_FLAG2 = 2;

    // Reset values.
    localparam logic [PIN_N-1:0]  RST_FUNC  = 12'h000;
    localparam logic [PIN_N-1:0]  RST_DIR   = 12'h000;
    localparam logic [4:0]        RST_CCTRL = 5'h00;
    localparam logic [7:0]        RST_RCTRL = 8'h00;
    localparam logic [6:0]        RST_TCTRL = 7'h00;
    localparam logic [FLAG_N-1:0] RST_FLAGS = 3'h0;

    typedef enum logic [1:0]
    {
        PIN_OFF,
        PIN_GPIO_IN,
        PIN_GPIO_OUT,
        PIN_PERIPH
    } apfg_pin_mode_t;

    typedef enum logic [1:0]
    {
        RX_HOLD,
        RX_IDLE,
        RX_WAIT_SYNC,
        RX_RUN
    } apfg_rx_state_t;

endpackage

// ---- rtl/apfg_sync.sv ----
// Three-stage input synchroniser that accepts a level once stages agree.
module apfg_sync
(
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic raw,
    output logic      level
);

    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end
        else
        begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change counts only once the second and third stages agree.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            level <= 1'b0;
        else if (stage2 == stage3)
            level <= stage3;
    end

endmodule

// ---- rtl/apfg_top.sv ----
// Serial flag pins, general-purpose port and section sequencing.
module apfg_top
(
    input  wire logic                         ref_clk,
    input  wire logic                         reset,
    input  wire logic [apfg_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [apfg_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [apfg_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic [apfg_pkg::PIN_N-1:0]   port_in,
    output logic      [apfg_pkg::PIN_N-1:0]   port_out,
    output logic      [apfg_pkg::PIN_N-1:0]   port_oe,
    input  wire logic [apfg_pkg::PIN_N-1:0]   periph_out,
    input  wire logic [apfg_pkg::PIN_N-1:0]   periph_oe,
    output logic      [apfg_pkg::PIN_N-1:0]   periph_in,
    input  wire logic                         rx_first_bit,
    input  wire logic                         rx_word_done,
    input  wire logic                         rx_frame_sync,
    input  wire logic                         tx_frame_sync,
    input  wire logic                         tx_load,
    input  wire logic                         tx_empty,
    input  wire logic                         core_irq_req,
    output logic                              irq_req_out,
    output logic                              tx_section_reset,
    output logic                              rx_section_reset,
    output logic                              clock_gen_run,
    output logic                              rx_accept,
    output logic      [apfg_pkg::TX_N-1:0]    tx_drive,
    output logic                              sync_mode,
    output logic                              tx_buffer_enable_sel
);

    localparam int unsigned PN = apfg_pkg::PIN_N;
    localparam int unsigned FN = apfg_pkg::FLAG_N;

    function automatic apfg_pkg::apfg_pin_mode_t pin_mode
    (
        input logic func_bit,
        input logic dir_bit
    );
        case ({func_bit, dir_bit})
            2'b00:   return apfg_pkg::PIN_OFF;
            2'b01:   return apfg_pkg::PIN_GPIO_OUT;
            2'b10:   return apfg_pkg::PIN_GPIO_IN;
            default: return apfg_pkg::PIN_PERIPH;
        endcase
    endfunction

    logic [PN-1:0]               port_function_control;
    logic [PN-1:0]               port_direction_control;
    logic [PN-1:0]               port_pin_data;
    logic [4:0]                  common_control_register;
    logic [7:0]                  receive_control_register;
    logic [6:0]                  transmit_control_register;
    logic [FN-1:0]               input_flag_latch;
    logic [FN-1:0]               input_flag_status;
    logic [FN-1:0]               output_flag_pin;
    logic [apfg_pkg::TX_N-1:0]   tx_armed;
    apfg_pkg::apfg_rx_state_t    rx_state;
    apfg_pkg::apfg_rx_state_t    next_rx_state;
    logic [PN-1:0]               pin_level;
    logic [PN-1:0]               next_port_out;
    logic [PN-1:0]               next_port_oe;
    logic [PN-1:0]               gpio_in_mask;
    logic [PN-1:0]               flag_en;
    logic [PN-1:0]               flag_dir;
    logic [PN-1:0]               flag_val;
    logic [FN-1:0]               flag_en3;
    logic [FN-1:0]               flag_dir3;
    logic [apfg_pkg::RX_N-1:0]   receiver_enable_bits;
    logic [apfg_pkg::TX_N-1:0]   transmitter_enable_bits;
    logic                        individual_reset;
    logic [PN-1:0]               periph_mask;
    logic [apfg_pkg::DATA_W-1:0] read_value;

    assign sync_mode =
        common_control_register[apfg_pkg::CC_SYNC_BIT];
    assign tx_buffer_enable_sel =
        common_control_register[apfg_pkg::CC_TX_BUFFER_ENABLE_SELECT_BIT];
    assign receiver_enable_bits =
        receive_control_register[apfg_pkg::RC_EN_LO +: apfg_pkg::RX_N];
    assign transmitter_enable_bits =
        transmit_control_register[apfg_pkg::TC_EN_LO +: apfg_pkg::TX_N];

    // Port configuration registers; upper twelve bits read as zero.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            port_function_control  <= apfg_pkg::RST_FUNC;
            port_direction_control <= apfg_pkg::RST_DIR;
        end
        else
        begin
            if (reg_wr && (reg_addr == apfg_pkg::REG_FUNC))
                port_function_control <= reg_wdata[PN-1:0];
            if (reg_wr && (reg_addr == apfg_pkg::REG_DIR))
                port_direction_control <= reg_wdata[PN-1:0];
        end
    end

    // Pin data has no reset, so disconnected pins keep whatever it holds.
    always_ff @(posedge ref_clk)
    begin
        if (reg_wr && (reg_addr == apfg_pkg::REG_DATA))
            port_pin_data <= reg_wdata[PN-1:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            common_control_register   <= apfg_pkg::RST_CCTRL;
            receive_control_register  <= apfg_pkg::RST_RCTRL;
            transmit_control_register <= apfg_pkg::RST_TCTRL;
        end
        else
        begin
            if (reg_wr && (reg_addr == apfg_pkg::REG_CCTRL))
                common_control_register <= reg_wdata[4:0];
            if (reg_wr && (reg_addr == apfg_pkg::REG_RCTRL))
                receive_control_register <= reg_wdata[7:0];
            if (reg_wr && (reg_addr == apfg_pkg::REG_TCTRL))
                transmit_control_register <= reg_wdata[6:0];
        end
    end

    // Section resets and clock generator enable.
    assign individual_reset = (port_function_control == '0) &&
                              (port_direction_control == '0);
    assign tx_section_reset = reset || individual_reset ||
        transmit_control_register[apfg_pkg::TC_HOLD_BIT];
    assign rx_section_reset = reset || individual_reset ||
        receive_control_register[apfg_pkg::RC_HOLD_BIT];
    assign clock_gen_run = !individual_reset;

    // Interrupt requests pass only while some section is enabled.
    assign irq_req_out = core_irq_req && !individual_reset &&
        ((|transmitter_enable_bits) || (|receiver_enable_bits));

    always_comb
    begin
        next_rx_state = rx_state;
        case (rx_state)
            apfg_pkg::RX_HOLD:
                next_rx_state = apfg_pkg::RX_IDLE;
            apfg_pkg::RX_IDLE:
                if (|receiver_enable_bits)
                    next_rx_state = apfg_pkg::RX_WAIT_SYNC;
            apfg_pkg::RX_WAIT_SYNC:
                if (receiver_enable_bits == '0)
                    next_rx_state = apfg_pkg::RX_IDLE;
                else if (rx_frame_sync)
                    next_rx_state = apfg_pkg::RX_RUN;
            apfg_pkg::RX_RUN:
                if (receiver_enable_bits == '0)
                    next_rx_state = apfg_pkg::RX_IDLE;
            default:
                next_rx_state = apfg_pkg::RX_HOLD;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rx_section_reset)
            rx_state <= apfg_pkg::RX_HOLD;
        else
            rx_state <= next_rx_state;
    end

    assign rx_accept = (rx_state == apfg_pkg::RX_RUN);

    // Each transmitter arms on the first frame sync after its enable.
    always_ff @(posedge ref_clk)
    begin
        if (tx_section_reset)
            tx_armed <= '0;
        else
            tx_armed <= transmitter_enable_bits &
                        (tx_armed | {apfg_pkg::TX_N{tx_frame_sync}});
    end

    assign tx_drive = tx_armed;

    // Flag availability and direction for pins 0 to 2.
    always_comb
    begin
        flag_en3  = '0;
        flag_dir3 = '0;
        if (sync_mode)
        begin
            flag_en3[0] = periph_mask[apfg_pkg::PIN_FLAG0];
            flag_en3[1] = periph_mask[apfg_pkg::PIN_FLAG1] &&
                          !tx_buffer_enable_sel;
            flag_en3[2] = periph_mask[apfg_pkg::PIN_FLAG2];
        end
        flag_dir3[0] =
            receive_control_register[apfg_pkg::RC_CKD_BIT];
        flag_dir3[1] =
            receive_control_register[apfg_pkg::RC_FSD_BIT];
        flag_dir3[2] =
            receive_control_register[apfg_pkg::RC_HCKD_BIT];
    end

    assign flag_en  = {{(PN-FN){1'b0}}, flag_en3};
    assign flag_dir = {{(PN-FN){1'b0}}, flag_dir3};
    assign flag_val = {{(PN-FN){1'b0}}, output_flag_pin};

    // Input flags are caught with the first bit of each received word.
    always_ff @(posedge ref_clk)
    begin
        if (rx_section_reset)
            input_flag_latch <= apfg_pkg::RST_FLAGS;
        else if (rx_first_bit && rx_accept)
        begin
            for (int f = 0; f < FN; f++)
            begin
                if (flag_en3[f] && !flag_dir3[f])
                    input_flag_latch[f] <= pin_level[f];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rx_section_reset)
            input_flag_status <= apfg_pkg::RST_FLAGS;
        else if (rx_word_done && rx_accept)
            input_flag_status <= input_flag_latch;
    end

    // Output flags change only when a word is loaded for transmission, and clear in transmit section reset.
    always_ff @(posedge ref_clk)
    begin
        if (tx_section_reset)
            output_flag_pin <= apfg_pkg::RST_FLAGS;
        else if (tx_load)
            output_flag_pin <= common_control_register[
                apfg_pkg::CC_OFLAG_LO +: FN];
    end

    // Per-pin synchronisation and drive selection.
    for (genvar i = 0; i < PN; i++)
    begin : g_pin
        apfg_pkg::apfg_pin_mode_t mode;

        apfg_sync u_sync
        (
            .ref_clk (ref_clk),
            .reset   (reset),
            .raw     (port_in[i]),
            .level   (pin_level[i])
        );

        assign mode = pin_mode(port_function_control[i],
                               port_direction_control[i]);
        assign gpio_in_mask[i] = (mode == apfg_pkg::PIN_GPIO_IN);
        assign periph_mask[i]  = (mode == apfg_pkg::PIN_PERIPH);

        always_comb
        begin
            next_port_out[i] = 1'b0;
            next_port_oe[i]  = 1'b0;
            case (mode)
                apfg_pkg::PIN_GPIO_OUT:
                begin
                    next_port_out[i] = port_pin_data[i];
                    next_port_oe[i]  = 1'b1;
                end
                apfg_pkg::PIN_PERIPH:
                    if (flag_en[i])
                    begin
                        next_port_out[i] = flag_dir[i] & flag_val[i];
                        next_port_oe[i]  = flag_dir[i];
                    end
                    else
                    begin
                        next_port_out[i] = periph_oe[i] & periph_out[i];
                        next_port_oe[i]  = periph_oe[i];
                    end
                default:
                    next_port_oe[i]  = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            port_out <= '0;
            port_oe  <= '0;
        end
        else
        begin
            port_out <= next_port_out;
            port_oe  <= next_port_oe;
        end
    end

    assign periph_in = pin_level;

    always_comb
    begin
        read_value = '0;
        case (reg_addr)
            apfg_pkg::REG_FUNC:
                read_value[PN-1:0] = port_function_control;
            apfg_pkg::REG_DIR:
                read_value[PN-1:0] = port_direction_control;
            apfg_pkg::REG_DATA:
                read_value[PN-1:0] = (gpio_in_mask & pin_level) |
                    (~gpio_in_mask & port_pin_data);
            apfg_pkg::REG_CCTRL:
                read_value[4:0] = common_control_register;
            apfg_pkg::REG_RCTRL:
                read_value[7:0] = receive_control_register;
            apfg_pkg::REG_TCTRL:
                read_value[6:0] = transmit_control_register;
            apfg_pkg::REG_STAT:
            begin
                read_value[apfg_pkg::ST_IFLAG_LO +: FN] = input_flag_status;
                read_value[apfg_pkg::ST_TDE_BIT]   = tx_empty;
                read_value[apfg_pkg::ST_RXRUN_BIT] = rx_accept;
                read_value[apfg_pkg::ST_IRST_BIT]  = individual_reset;
            end
            default:
                read_value = '0;
        endcase
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge ref_clk)
    begin
        if (reg_rd && !reset)
            reg_rdata <= read_value;
        else
            reg_rdata <= '0;
    end

endmodule

// ---- dv/apfg_top_props.sv ----
// Port-level checker for the flag pins, port and section control.
module apfg_top_props
(
    input wire logic                        ref_clk,
    input wire logic                        reset,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [apfg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [apfg_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [apfg_pkg::PIN_N-1:0]  port_out,
    input wire logic [apfg_pkg::PIN_N-1:0]  port_oe,
    input wire logic                        rx_frame_sync,
    input wire logic                        tx_frame_sync,
    input wire logic                        tx_load,
    input wire logic                        irq_req_out,
    input wire logic                        tx_section_reset,
    input wire logic                        rx_section_reset,
    input wire logic                        clock_gen_run,
    input wire logic                        rx_accept,
    input wire logic [apfg_pkg::TX_N-1:0]   tx_drive,
    input wire logic                        sync_mode,
    input wire logic                        tx_buffer_enable_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside the answer cycle");
    AST_INDIV_RESET: assert property (!clock_gen_run |->
        tx_section_reset && rx_section_reset)
        else $error("sections not held in individual reset");
    AST_NO_IRQ: assert property (!clock_gen_run |-> !irq_req_out)
        else $error("interrupt passed while disabled");
    AST_PINS_OFF: assert property (!clock_gen_run |=> port_oe == '0)
        else $error("pin driven while disconnected");
    AST_OUT_QUIET: assert property ((port_out & ~port_oe) == '0)
        else $error("undriven pin shows a value");
    AST_TX_SYNC: assert property ((tx_drive & ~$past(tx_drive)) != '0
        |-> $past(tx_frame_sync))
        else $error("transmitter drives without frame sync");
    AST_RX_SYNC: assert property ($rose(rx_accept) |-> $past(rx_frame_sync))
        else $error("receiver runs without frame sync");
    AST_TX_HOLD: assert property (tx_section_reset |=> tx_drive == '0)
        else $error("transmitter drives in section reset");
    AST_RX_HOLD: assert property (rx_section_reset |=> !rx_accept)
        else $error("receiver runs in section reset");
    AST_FLAG_HOLD: assert property (sync_mode && !tx_buffer_enable_sel
        && !$past(reg_wr) && !$past(reg_wr, 2)
        && !($past(reg_wr, 3) && $past(reg_addr, 3) != apfg_pkg::REG_CCTRL)
        && !$past(tx_load) && !$past(tx_load, 2) |-> $stable(port_out[2:0]))
        else $error("flag pin changed between words");

    cover property ($rose(rx_accept));
    cover property ($rose(tx_drive[0]));
    cover property ($rose(clock_gen_run));
endmodule

// ---- dv/apfg_partner.sv ----
// Far-side pin model: resolves each pin and runs a link clock on pin 3.
module apfg_partner
(
    input  wire logic [11:0] port_out,
    input  wire logic [11:0] port_oe,
    input  wire logic [11:0] level,
    input  wire logic        link_run,
    output logic      [11:0] port_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lclk = 1'b0;
    always #80 lclk = link_run ? ~lclk : 1'b0;
    always_comb
    begin
        for (int i = 0; i < 12; i++)
            port_in[i] = port_oe[i] ? port_out[i] : level[i];
        if (!port_oe[3])
            port_in[3] = lclk;
    end
endmodule

// ---- dv/test_apfg_top.sv ----
// Directed bench for the flag pins, port and section control.
`define CHK(g, e) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("BAD %0t got %h want %h", $time, g, e); \
        end \
    end
module test_apfg_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FB = 0;
    localparam int WD = 1;
    localparam int RS = 2;
    localparam int TS = 3;
    localparam int TL = 4;
    logic        ref_clk = 0;
    logic        reset = 1;
    logic [2:0]  addr = '0;
    logic [23:0] wdata = '0;
    logic        wr = 0;
    logic        rd = 0;
    logic [23:0] rdv;
    logic [11:0] drv = '0;
    logic [11:0] pout = 12'h002;
    logic [11:0] poe = 12'h007;
    logic [4:0]  ev = '0;
    logic        temp = 0;
    logic        irq = 0;
    logic        link_run = 0;
    wire  [11:0] port_in, port_out, port_oe, periph_in;
    wire  [23:0] reg_rdata;
    wire         irq_out, txr, rxr, cgr, rxa, smode, tx_buffer_enable_select;
    wire  [5:0]  txd;
    int          fails = 0;
    int          samples_checked = 0;

    always #4 ref_clk = ~ref_clk;

    apfg_top i_apfg_top
    (
        .ref_clk(ref_clk), .reset(reset), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(reg_rdata),
        .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
        .periph_out(pout), .periph_oe(poe), .periph_in(periph_in),
        .rx_first_bit(ev[FB]), .rx_word_done(ev[WD]),
        .rx_frame_sync(ev[RS]), .tx_frame_sync(ev[TS]), .tx_load(ev[TL]),
        .tx_empty(temp), .core_irq_req(irq), .irq_req_out(irq_out),
        .tx_section_reset(txr), .rx_section_reset(rxr),
        .clock_gen_run(cgr), .rx_accept(rxa), .tx_drive(txd),
        .sync_mode(smode), .tx_buffer_enable_sel(tx_buffer_enable_select)
    );

    apfg_partner i_apfg_partner
    (
        .port_out(port_out), .port_oe(port_oe), .level(drv),
        .link_run(link_run), .port_in(port_in)
    );

    task automatic wr_reg(input logic [2:0] a, input logic [23:0] d);
        @(posedge ref_clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 0;
    endtask

    task automatic rd_reg(input logic [2:0] a);
        @(posedge ref_clk);
        rd <= 1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 0;
        #1;
        rdv = reg_rdata;
    endtask

    task automatic pulse(input int i);
        @(posedge ref_clk);
        ev[i] <= 1;
        @(posedge ref_clk);
        ev <= '0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #100us;
        fails++;
        test_done();
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset <= 0;
        rd_reg(apfg_pkg::REG_FUNC);
        `CHK(rdv, 24'h000000)
        rd_reg(apfg_pkg::REG_DIR);
        `CHK(rdv, 24'h000000)
        rd_reg(apfg_pkg::REG_STAT);
        `CHK(rdv, 24'h000020)
        `CHK({cgr, txr, rxr, txd}, 9'h0c0)
        wr_reg(3'h7, 24'hffffff);
        rd_reg(3'h7);
        `CHK(rdv, 24'h000000)
        wr_reg(apfg_pkg::REG_STAT, 24'hffffff);
        rd_reg(apfg_pkg::REG_STAT);
        `CHK(rdv, 24'h000020)
        wr_reg(apfg_pkg::REG_FUNC, 24'hffffff);
        rd_reg(apfg_pkg::REG_FUNC);
        `CHK(rdv, 24'h000fff)
        wr_reg(apfg_pkg::REG_DIR, 24'hfff000);
        rd_reg(apfg_pkg::REG_DIR);
        `CHK(rdv, 24'h000000)
        $display("test registers done");
        // Pins 11:8 GPIO out, 7:4 GPIO in, 3 off, 2:0 peripheral.
        @(posedge ref_clk);
        irq <= 1;
        link_run <= 1;
        wr_reg(apfg_pkg::REG_DATA, 24'h000a00);
        wr_reg(apfg_pkg::REG_FUNC, 24'h0000f7);
        wr_reg(apfg_pkg::REG_DIR, 24'h000f07);
        drv <= 12'h060;
        wt(6);
        `CHK(port_out[11:8], 4'ha)
        `CHK(port_oe[11:3], 9'h1e0)
        rd_reg(apfg_pkg::REG_DATA);
        `CHK(rdv[11:4], 8'ha6)
        `CHK(periph_in[7:4], 4'h6)
        `CHK(cgr, 1'b1)
        `CHK(irq_out, 1'b0)
        $display("test gpio done");
        wr_reg(apfg_pkg::REG_RCTRL, 24'h000061);
        wr_reg(apfg_pkg::REG_TCTRL, 24'h000001);
        wr_reg(apfg_pkg::REG_CCTRL, 24'h00000e);
        pulse(TL);
        wt(3);
        `CHK(port_out[2:0], 3'b010)
        @(posedge ref_clk);
        temp <= 1;
        rd_reg(apfg_pkg::REG_STAT);
        `CHK(rdv[3], 1'b1)
        wr_reg(apfg_pkg::REG_CCTRL, 24'h00000b);
        pulse(TL);
        wt(3);
        `CHK(port_out[1:0], 2'b01)
        `CHK(port_oe[2:0], 3'b011)
        wr_reg(apfg_pkg::REG_CCTRL, 24'h000005);
        wt(3);
        `CHK(port_out[1:0], 2'b01)
        pulse(TL);
        wt(3);
        `CHK(port_out[1:0], 2'b10)
        wr_reg(apfg_pkg::REG_CCTRL, 24'h000011);
        pulse(TL);
        wt(3);
        `CHK(port_out[1:0], 2'b10)
        `CHK({smode, tx_buffer_enable_select}, 2'b11)
        $display("test output flags done");
        `CHK({txd[0], rxa}, 2'b00)
        pulse(RS);
        pulse(TS);
        wt(1);
        `CHK({txd[0], rxa}, 2'b11)
        `CHK(irq_out, 1'b1)
        @(posedge ref_clk);
        drv <= 12'h064;
        wt(6);
        pulse(FB);
        drv <= 12'h060;
        wt(6);
        rd_reg(apfg_pkg::REG_STAT);
        `CHK(rdv[2], 1'b0)
        pulse(WD);
        wt(2);
        rd_reg(apfg_pkg::REG_STAT);
        `CHK(rdv[5:2], 4'b0111)
        $display("test input flag done");
        wr_reg(apfg_pkg::REG_TCTRL, 24'h000041);
        wt(2);
        `CHK({txr, rxr, txd[0], rxa}, 4'b1001)
        wr_reg(apfg_pkg::REG_RCTRL, 24'h000071);
        wt(2);
        `CHK({txr, rxr, rxa}, 3'b110)
        wr_reg(apfg_pkg::REG_TCTRL, 24'h000040);
        wr_reg(apfg_pkg::REG_TCTRL, 24'h000000);
        wr_reg(apfg_pkg::REG_TCTRL, 24'h000001);
        wt(2);
        `CHK(txd[0], 1'b0)
        pulse(TS);
        wt(1);
        `CHK(txd[0], 1'b1)
        wr_reg(apfg_pkg::REG_RCTRL, 24'h000070);
        wr_reg(apfg_pkg::REG_RCTRL, 24'h000060);
        wr_reg(apfg_pkg::REG_RCTRL, 24'h000061);
        wr_reg(apfg_pkg::REG_FUNC, 24'h000000);
        wr_reg(apfg_pkg::REG_DIR, 24'h000000);
        wt(2);
        `CHK({cgr, txr, rxr, irq_out}, 4'b0110)
        $display("test sections done");
        test_done();
    end
endmodule

bind apfg_top apfg_top_props i_apfg_top_props
(
    .ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .port_out(port_out), .port_oe(port_oe),
    .rx_frame_sync(rx_frame_sync), .tx_frame_sync(tx_frame_sync),
    .tx_load(tx_load), .irq_req_out(irq_req_out),
    .tx_section_reset(tx_section_reset),
    .rx_section_reset(rx_section_reset), .clock_gen_run(clock_gen_run),
    .rx_accept(rx_accept), .tx_drive(tx_drive), .sync_mode(sync_mode),
    .tx_buffer_enable_sel(tx_buffer_enable_sel)
);
